// File: design/decoder_defines.vh
// Opcodes, modifiers and fixed values of the decoder.
// Assumes a Verilog-2005 compiler.
`ifndef DECODER_DEFINES_VH
`define DECODER_DEFINES_VH
`define OPC_COND_JUMP 4'h1
`define OPC_PAIR 4'h2
`define OPC_INDIRECT 4'h3
`define OPC_LONG_JUMP 4'h4
`define OPC_CALL 4'h5
`define OPC_INCREMENT 4'h6
`define OPC_INC_SKIP 4'h7
`define OPC_ADD 4'h8
`define OPC_SUB 4'h9
`define OPC_LOAD 4'ha
`define OPC_SWAP 4'hb
`define OPC_RETURN 4'hc
`define OPC_LOAD_IMM 4'hd
`define OPC_IO 4'he
`define OPC_ACC_GROUP 4'hf
`define IO_SUB_CHAR 4'h8
`define IO_READ_CHAR 4'h9
`define IO_READ_PORT 4'ha
`define IO_ADD_CHAR 4'hb
`define IO_STATUS_READ 2'h3
`define ACC_CLEAR_BOTH 4'h0
`define ACC_CLEAR_CARRY 4'h1
`define ACC_INCREMENT 4'h2
`define ACC_INVERT_CARRY 4'h3
`define ACC_INVERT 4'h4
`define ACC_ROTATE_LEFT 4'h5
`define ACC_ROTATE_RIGHT 4'h6
`define ACC_CARRY_TO_ACC 4'h7
`define ACC_DECREMENT 4'h8
`define ACC_CARRY_SUB 4'h9
`define ACC_SET_CARRY 4'ha
`define ACC_DECIMAL 4'hb
`define ACC_ONE_HOT 4'hc
`define ACC_COMMAND_LINE 4'hd
`define COND_INVERT 3
`define COND_ZERO 2
`define COND_CARRY 1
`define COND_TEST 0
`define RESET_ADDRESS 12'h000
`define ZERO_NIBBLE 4'h0
`define ALL_ONES_NIBBLE 4'hf
`define DECIMAL_LIMIT 4'h9
`define DECIMAL_FIX 4'h6
`define CARRY_SUB_SET 4'ha
`define CARRY_SUB_CLEAR 4'h9
`endif

// File: design/nibble_alu.v
// Accumulator and carry update of every instruction.
// Assumes the caller picks the operand nibble.
`include "decoder_defines.vh"

module nibble_alu
(
   input  wire [3:0] opcode,
   input  wire [3:0] modifier,
   input  wire [3:0] accumulator,
   input  wire       carry,
   input  wire [3:0] operand,
   output reg  [3:0] result_acc,
   output reg        result_carry
);

   wire [4:0] sum_with_carry = {1'b0, accumulator} + {1'b0, operand} + {4'h0, carry};
   // Carry set after a subtract means no borrow occurred
   wire [4:0] diff_with_borrow = {1'b0, accumulator} + {1'b0, ~operand} + {4'h0, ~carry};
   wire [4:0] acc_plus_one = {1'b0, accumulator} + 5'h01;
   wire [4:0] acc_decimal = {1'b0, accumulator} + {1'b0, `DECIMAL_FIX};

   always @*
   begin
      result_acc = accumulator;
      result_carry = carry;
      case (opcode)
         `OPC_ADD: {result_carry, result_acc} = sum_with_carry;
         `OPC_SUB: {result_carry, result_acc} = diff_with_borrow;
         `OPC_LOAD, `OPC_SWAP: result_acc = operand;
         `OPC_RETURN, `OPC_LOAD_IMM: result_acc = modifier;
         `OPC_IO:
         begin
            if (modifier == `IO_SUB_CHAR)
               {result_carry, result_acc} = diff_with_borrow;
            else if (modifier == `IO_ADD_CHAR)
               {result_carry, result_acc} = sum_with_carry;
            else if (modifier == `IO_READ_CHAR || modifier == `IO_READ_PORT)
               result_acc = operand;
            else if (modifier[3:2] == `IO_STATUS_READ)
               result_acc = operand;
         end
         `OPC_ACC_GROUP:
         begin
            case (modifier)
               `ACC_CLEAR_BOTH: {result_carry, result_acc} = 5'h00;
               `ACC_CLEAR_CARRY: result_carry = 1'b0;
               `ACC_INCREMENT: {result_carry, result_acc} = acc_plus_one;
               `ACC_INVERT_CARRY: result_carry = ~carry;
               `ACC_INVERT: result_acc = ~accumulator;
               `ACC_ROTATE_LEFT: {result_carry, result_acc} = {accumulator, carry};
               `ACC_ROTATE_RIGHT: {result_acc, result_carry} = {carry, accumulator};
               `ACC_CARRY_TO_ACC:
               begin
                  result_acc = {3'h0, carry};
                  result_carry = 1'b0;
               end
               `ACC_DECREMENT:
               begin
                  // Carry set means the decrement did not borrow
                  result_acc = accumulator - 4'h1;
                  result_carry = (accumulator != `ZERO_NIBBLE);
               end
               `ACC_CARRY_SUB:
               begin
                  result_acc = carry ? `CARRY_SUB_SET : `CARRY_SUB_CLEAR;
                  result_carry = 1'b0;
               end
               `ACC_SET_CARRY: result_carry = 1'b1;
               `ACC_DECIMAL:
               begin
                  // Carry is only ever set here, never cleared
                  if (carry || accumulator > `DECIMAL_LIMIT)
                  begin
                     result_acc = acc_decimal[3:0];
                     result_carry = carry | acc_decimal[4];
                  end
               end
               `ACC_ONE_HOT:
               begin
                  case (accumulator)
                     4'h0: result_acc = 4'h0;
                     4'h1: result_acc = 4'h1;
                     4'h2: result_acc = 4'h2;
                     4'h4: result_acc = 4'h3;
                     4'h8: result_acc = 4'h4;
                     default: result_acc = `ALL_ONES_NIBBLE;
                  endcase
               end
               default: result_acc = accumulator;
            endcase
         end
         default: result_acc = accumulator;
      endcase
   end

endmodule

// File: design/nibble_cpu_instruction_decoder.v
// Instruction sequencer and executor of a 4-bit processor.
// Assumes memory and I/O answer by ready handshakes on this clock.
//
// Operation
// - Two-word instructions fetch an operand word next
// - Opcode nibble fetched before modifier nibble
// - Conditional jump loads in-page target if true
// - Condition bits: invert, zero acc, carry, test low
// - Fetch immediate loads operand into register pair
// - Send pair contents as chip select address
// - Indirect fetch via pair zero into pair
// - Indirect jump uses pair as low address
// - Long jump to modifier plus operand target
// - Call pushes return address, jumps long
// - Increment named index register
// - Increment, jump in page if nonzero
// - Add with carry, subtract with borrow
// - Load register, or swap with accumulator
// - Return pops stack; load modifier to accumulator
// - I/O group acts on last chip select
// - Write accumulator to char, ports, program memory
// - Status write index comes from modifier
// - Subtract, read, read port, add character
// - Read status character 0 through 3
// - Clear, increment, invert, rotate through carry
// - Carry move, decrement, adjust, one-hot, command line
`include "decoder_defines.vh"

module nibble_cpu_instruction_decoder
#(
   parameter STACK_DEPTH = 3,
   parameter STACK_WIDTH = 2
)
(
   input  wire        clock,
   input  wire        reset_n,
   input  wire        test_input,
   output reg  [11:0] prog_address,
   output reg         prog_upper,
   output wire        prog_request,
   input  wire [3:0]  prog_nibble,
   input  wire        prog_ready,
   output reg  [7:0]  chip_select_address,
   output reg         chip_select_strobe,
   output wire        io_request,
   output wire [3:0]  io_command,
   output wire [3:0]  io_write_data,
   input  wire [3:0]  io_read_data,
   input  wire        io_ready,
   output reg  [3:0]  accumulator,
   output reg         carry,
   output reg  [2:0]  command_line
);

   ////////////////////////////////////////////////////////////////////////////
   // State encoding

   localparam [7:0] ST_FETCH_HIGH = 8'h01;
   localparam [7:0] ST_FETCH_LOW  = 8'h02;
   localparam [7:0] ST_OPND_HIGH  = 8'h04;
   localparam [7:0] ST_OPND_LOW   = 8'h08;
   localparam [7:0] ST_IND_HIGH   = 8'h10;
   localparam [7:0] ST_IND_LOW    = 8'h20;
   localparam [7:0] ST_EXECUTE    = 8'h40;
   localparam [7:0] ST_IO         = 8'h80;
   localparam [31:0] STACK_TOP    = STACK_DEPTH - 1;

   reg [7:0]             state;
   reg [3:0]             opcode_nibble;
   reg [3:0]             modifier_nibble;
   reg [7:0]             operand;
   reg [11:0]            saved_address;
   reg [STACK_WIDTH-1:0] stack_pointer;
   reg [3:0]             index_file [0:15];
   reg [11:0]            stack_mem [0:STACK_DEPTH-1];
   integer               i;

   wire [3:0] alu_acc;
   wire       alu_carry;
   wire [3:0] alu_operand;
   wire [3:0] incremented;
   wire [2:0] pair;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Even register of a pair holds the upper nibble
   function [7:0] pair_value;
      input [2:0] sel;
      begin
         pair_value = {index_file[{sel, 1'b0}], index_file[{sel, 1'b1}]};
      end
   endfunction

   function two_word;
      input [3:0] opc;
      input [3:0] mdf;
      begin
         two_word = (opc == `OPC_COND_JUMP) || (opc == `OPC_LONG_JUMP) ||
                    (opc == `OPC_CALL) || (opc == `OPC_INC_SKIP) ||
                    (opc == `OPC_PAIR && !mdf[0]);
      end
   endfunction

   // Selected tests are ORed, then optionally inverted
   function jump_condition;
      input [3:0] cond;
      input [3:0] acc;
      input       cy;
      input       test;
      reg         hit;
      begin
         hit = (cond[`COND_ZERO] && acc == `ZERO_NIBBLE) ||
               (cond[`COND_CARRY] && cy) ||
               (cond[`COND_TEST] && !test);
         jump_condition = cond[`COND_INVERT] ? !hit : hit;
      end
   endfunction

   // Stack wraps at its depth; overflow overwrites the oldest level
   function [STACK_WIDTH-1:0] stack_step;
      input [STACK_WIDTH-1:0] ptr;
      input                   up;
      begin
         if (up)
            stack_step = (ptr == STACK_TOP[STACK_WIDTH-1:0]) ? {STACK_WIDTH{1'b0}} : ptr + 1'b1;
         else
            stack_step = (ptr == {STACK_WIDTH{1'b0}}) ? STACK_TOP[STACK_WIDTH-1:0] : ptr - 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Datapath

   assign pair = modifier_nibble[3:1];
   assign incremented = index_file[modifier_nibble] + 4'h1;
   assign alu_operand = (state == ST_IO) ? io_read_data : index_file[modifier_nibble];
   assign prog_request = |(state & (ST_FETCH_HIGH | ST_FETCH_LOW | ST_OPND_HIGH |
                                    ST_OPND_LOW | ST_IND_HIGH | ST_IND_LOW));
   // The chip select address stays held on its own port; this port only tags the operation
   assign io_request = (state == ST_IO);
   assign io_command = modifier_nibble;
   assign io_write_data = accumulator;

   nibble_alu alu
   (
      .opcode       (opcode_nibble),
      .modifier     (modifier_nibble),
      .accumulator  (accumulator),
      .carry        (carry),
      .operand      (alu_operand),
      .result_acc   (alu_acc),
      .result_carry (alu_carry)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         state <= ST_FETCH_HIGH;
         prog_address <= `RESET_ADDRESS;
         prog_upper <= 1'b1;
         opcode_nibble <= `ZERO_NIBBLE;
         modifier_nibble <= `ZERO_NIBBLE;
         operand <= 8'h00;
         saved_address <= `RESET_ADDRESS;
         stack_pointer <= {STACK_WIDTH{1'b0}};
         chip_select_address <= 8'h00;
         chip_select_strobe <= 1'b0;
         accumulator <= `ZERO_NIBBLE;
         carry <= 1'b0;
         command_line <= 3'h0;
         for (i = 0; i < 16; i = i + 1)
            index_file[i] <= `ZERO_NIBBLE;
         for (i = 0; i < STACK_DEPTH; i = i + 1)
            stack_mem[i] <= `RESET_ADDRESS;
      end
      else
      begin
         chip_select_strobe <= 1'b0;
         case (state)
            ST_FETCH_HIGH:
            begin
               if (prog_ready)
               begin
                  opcode_nibble <= prog_nibble;
                  prog_upper <= 1'b0;
                  state <= ST_FETCH_LOW;
               end
            end
            ST_FETCH_LOW:
            begin
               if (prog_ready)
               begin
                  modifier_nibble <= prog_nibble;
                  prog_upper <= 1'b1;
                  if (opcode_nibble == `OPC_INDIRECT && !prog_nibble[0])
                  begin
                     // Pair zero addresses the current page; resume after it
                     saved_address <= prog_address + 12'h001;
                     prog_address <= {prog_address[11:8], pair_value(3'h0)};
                     state <= ST_IND_HIGH;
                  end
                  else
                  begin
                     prog_address <= prog_address + 12'h001;
                     if (two_word(opcode_nibble, prog_nibble))
                        state <= ST_OPND_HIGH;
                     else if (opcode_nibble == `OPC_IO)
                        state <= ST_IO;
                     else
                        state <= ST_EXECUTE;
                  end
               end
            end
            ST_OPND_HIGH, ST_IND_HIGH:
            begin
               if (prog_ready)
               begin
                  operand[7:4] <= prog_nibble;
                  prog_upper <= 1'b0;
                  state <= (state == ST_OPND_HIGH) ? ST_OPND_LOW : ST_IND_LOW;
               end
            end
            ST_OPND_LOW:
            begin
               if (prog_ready)
               begin
                  operand[3:0] <= prog_nibble;
                  prog_upper <= 1'b1;
                  prog_address <= prog_address + 12'h001;
                  state <= ST_EXECUTE;
               end
            end
            ST_IND_LOW:
            begin
               if (prog_ready)
               begin
                  operand[3:0] <= prog_nibble;
                  prog_upper <= 1'b1;
                  prog_address <= saved_address;
                  state <= ST_EXECUTE;
               end
            end
            ST_IO:
            begin
               // Write commands leave the accumulator as it is
               if (io_ready)
               begin
                  accumulator <= alu_acc;
                  carry <= alu_carry;
                  state <= ST_FETCH_HIGH;
               end
            end
            ST_EXECUTE:
            begin
               accumulator <= alu_acc;
               carry <= alu_carry;
               state <= ST_FETCH_HIGH;
               case (opcode_nibble)
                  `OPC_COND_JUMP:
                  begin
                     if (jump_condition(modifier_nibble, accumulator, carry, test_input))
                        prog_address <= {prog_address[11:8], operand};
                  end
                  `OPC_PAIR:
                  begin
                     if (modifier_nibble[0])
                     begin
                        chip_select_address <= pair_value(pair);
                        chip_select_strobe <= 1'b1;
                     end
                     else
                     begin
                        index_file[{pair, 1'b0}] <= operand[7:4];
                        index_file[{pair, 1'b1}] <= operand[3:0];
                     end
                  end
                  `OPC_INDIRECT:
                  begin
                     if (modifier_nibble[0])
                        prog_address[7:0] <= pair_value(pair);
                     else
                     begin
                        index_file[{pair, 1'b0}] <= operand[7:4];
                        index_file[{pair, 1'b1}] <= operand[3:0];
                     end
                  end
                  `OPC_LONG_JUMP: prog_address <= {modifier_nibble, operand};
                  `OPC_CALL:
                  begin
                     stack_mem[stack_pointer] <= prog_address;
                     stack_pointer <= stack_step(stack_pointer, 1'b1);
                     prog_address <= {modifier_nibble, operand};
                  end
                  `OPC_INCREMENT: index_file[modifier_nibble] <= incremented;
                  `OPC_INC_SKIP:
                  begin
                     index_file[modifier_nibble] <= incremented;
                     if (incremented != `ZERO_NIBBLE)
                        prog_address <= {prog_address[11:8], operand};
                  end
                  `OPC_SWAP: index_file[modifier_nibble] <= accumulator;
                  `OPC_RETURN:
                  begin
                     stack_pointer <= stack_step(stack_pointer, 1'b0);
                     prog_address <= stack_mem[stack_step(stack_pointer, 1'b0)];
                  end
                  `OPC_ACC_GROUP:
                  begin
                     if (modifier_nibble == `ACC_COMMAND_LINE)
                        command_line <= accumulator[2:0];
                  end
                  default: command_line <= command_line;
               endcase
            end
            default: state <= ST_FETCH_HIGH;
         endcase
      end
   end

endmodule

// File: tb/decoder_assertions.sv
// Checker of fetch, chip-select and I/O handshakes.
// Assumes it is bound to the decoder's ports.
module decoder_assertions
(
   input wire        clock,
   input wire        reset_n,
   input wire [11:0] prog_address,
   input wire        prog_upper,
   input wire        prog_request,
   input wire        prog_ready,
   input wire [7:0]  chip_select_address,
   input wire        chip_select_strobe,
   input wire        io_request,
   input wire [3:0]  io_command,
   input wire [3:0]  io_write_data,
   input wire [3:0]  io_read_data,
   input wire        io_ready,
   input wire [3:0]  accumulator,
   input wire        carry,
   input wire [2:0]  command_line
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////
   fetch_wait_hold_a: assert property (prog_request && !prog_ready |=> $stable(prog_address) && $stable(prog_upper))
      else $error("fetch moved");
   upper_then_lower_a: assert property (prog_request && prog_ready && prog_upper |=> !prog_upper && $stable(prog_address))
      else $error("no lower nibble");
   lower_then_upper_a: assert property (prog_request && prog_ready && !prog_upper |=> prog_upper)
      else $error("no upper nibble");
   strobe_single_a: assert property (chip_select_strobe |=> !chip_select_strobe)
      else $error("strobe too long");
   select_kept_a: assert property (!chip_select_strobe |-> $stable(chip_select_address))
      else $error("select moved");
   io_hold_a: assert property (io_request && !io_ready |=> io_request && $stable(io_command) && $stable(io_write_data))
      else $error("io request changed");
   write_data_acc_a: assert property (io_request && !io_command[3] |-> io_write_data == accumulator)
      else $error("bad write data");
   write_keeps_acc_a: assert property (io_request && io_ready && !io_command[3] |=> $stable(accumulator) && $stable(carry))
      else $error("write changed acc");
   read_loads_acc_a: assert property (io_request && io_ready && (io_command == 4'h9 || io_command == 4'ha || io_command[3:2] == 2'b11)
      |=> accumulator == $past(io_read_data))
      else $error("read not loaded");
   command_from_acc_a: assert property ($changed(command_line) |-> command_line == $past(accumulator[2:0]))
      else $error("bad command line");
endmodule

bind nibble_cpu_instruction_decoder decoder_assertions i_decoder_assertions (.*);

// File: tb/memory_model.sv
// Program memory and RAM/ROM chips facing the decoder.
// Assumes the bench fills rom; slow halves the answer rate.
module memory_model
(
   input  wire        clock,
   input  wire        slow,
   input  wire [11:0] prog_address,
   input  wire        prog_upper,
   input  wire        prog_request,
   output logic [3:0] prog_nibble,
   output logic       prog_ready,
   input  wire [7:0]  chip_select_address,
   input  wire        io_request,
   input  wire [3:0]  io_command,
   input  wire [3:0]  io_write_data,
   output logic [3:0] io_read_data,
   output logic       io_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rom [0:4095];
   logic [3:0] ram_main [0:255];
   logic [3:0] ram_status [0:63];
   logic       phase = 1'b0;
   logic [3:0] noise = 4'h0;
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock)
   begin
      phase <= ~phase;
      noise <= noise + 4'h7;
      if (io_request && io_ready && io_command == 4'h0)
         ram_main[chip_select_address] <= io_write_data;
      if (io_request && io_ready && io_command[3:2] == 2'b01)
         ram_status[{chip_select_address[7:4], io_command[1:0]}] <= io_write_data;
   end
   assign prog_ready = !slow || phase;
   assign io_ready = !slow || !phase;
   // Lines show churn while not answering, so a stale sample cannot pass
   assign prog_nibble = !prog_ready ? noise : prog_upper ? rom[prog_address][7:4] : rom[prog_address][3:0];
   assign io_read_data = !io_ready ? ~noise
                       : io_command == 4'ha ? chip_select_address[3:0] ^ 4'ha
                       : io_command[3:2] == 2'b11 ? ram_status[{chip_select_address[7:4], io_command[1:0]}]
                       : ram_main[chip_select_address];
endmodule

// File: tb/tb.sv
// Bench: random programs run to a stop loop at 040.
// Assumes the decoder and memory model; reads ports.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        test_input = 1'b0;
   logic        slow = 1'b0;
   logic [11:0] prog_address;
   logic        prog_upper, prog_request, prog_ready, chip_select_strobe, io_request, io_ready, carry;
   logic [3:0]  prog_nibble, io_command, io_write_data, io_read_data, accumulator;
   logic [7:0]  chip_select_address;
   logic [2:0]  command_line;
   integer      seed = 39;
   integer      fail_count = 0;
   integer      checks = 0;
   integer      k;
   logic [11:0] pc;
   logic [3:0]  a, m, r, v, w, op;
   logic [7:0]  b;
   logic [4:0]  e;
   logic        c, j;
   always #2.5 clock = ~clock;
   nibble_cpu_instruction_decoder i_nibble_cpu_instruction_decoder
   (
      .clock(clock), .reset_n(reset_n), .test_input(test_input), .prog_address(prog_address),
      .prog_upper(prog_upper), .prog_request(prog_request), .prog_nibble(prog_nibble), .prog_ready(prog_ready),
      .chip_select_address(chip_select_address), .chip_select_strobe(chip_select_strobe),
      .io_request(io_request), .io_command(io_command), .io_write_data(io_write_data),
      .io_read_data(io_read_data), .io_ready(io_ready), .accumulator(accumulator), .carry(carry),
      .command_line(command_line)
   );
   memory_model i_memory_model
   (
      .clock(clock), .slow(slow), .prog_address(prog_address), .prog_upper(prog_upper),
      .prog_request(prog_request), .prog_nibble(prog_nibble), .prog_ready(prog_ready),
      .chip_select_address(chip_select_address), .io_request(io_request), .io_command(io_command),
      .io_write_data(io_write_data), .io_read_data(io_read_data), .io_ready(io_ready)
   );
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] acc_op(input logic [3:0] md, ac, input logic cy);
      case (md)
         4'h0: return 5'h00;
         4'h1: return {1'b0, ac};
         4'h2: return {1'b0, ac} + 5'h1;
         4'h3: return {~cy, ac};
         4'h4: return {cy, ~ac};
         4'h5: return {ac, cy};
         4'h6: return {ac[0], cy, ac[3:1]};
         4'h7: return {4'h0, cy};
         4'h8: return {ac != 4'h0, ac - 4'h1};
         4'h9: return {1'b0, cy ? 4'ha : 4'h9};
         4'ha: return {1'b1, ac};
         4'hb: return (ac > 4'h9 || cy) ? ({1'b0, ac} + 5'h6) | {cy, 4'h0} : {cy, ac};
         4'hc: return {cy, ac == 4'h0 ? 4'h0 : ac == 4'h1 ? 4'h1 : ac == 4'h2 ? 4'h2 : ac == 4'h4 ? 4'h3
                              : ac == 4'h8 ? 4'h4 : 4'hf};
         default: return {cy, ac};
      endcase
   endfunction
   function automatic logic [4:0] add_sub(input logic [3:0] opc, ac, rg, input logic cy);
      if (opc == 4'h9)
         return {1'b0, ac} + {1'b0, ~rg} + {4'h0, ~cy};
      if (opc == 4'h8)
         return {1'b0, ac} + {1'b0, rg} + {4'h0, cy};
      return {cy, rg};
   endfunction
   function automatic logic jump_taken(input logic [3:0] cnd, ac, input logic cy, t);
      return ((cnd[2] && ac == 4'h0) || (cnd[1] && cy) || (cnd[0] && !t)) ^ cnd[3];
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task check(input string name, input logic [11:0] seen, input logic [11:0] expected);
      checks = checks + 1;
      if (seen !== expected)
      begin
         fail_count = fail_count + 1;
         $display("wrong value %s expected %h seen %h", name, expected, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task emit(input logic [15:0] two_bytes);
      i_memory_model.rom[pc] = two_bytes[15:8];
      i_memory_model.rom[pc + 12'h1] = two_bytes[7:0];
      pc = pc + 12'h2;
   endtask
   task start;
      reset_n = 1'b0;
      slow = $random(seed);
      test_input = $random(seed);
      pc = 12'h000;
   endtask
   // Bounded: a decoder that never reaches the stop loop ends the run
   task run;
      integer n;
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      n = 0;
      while (!(prog_address === 12'h040 && prog_request === 1'b1) && n < 400)
      begin
         @(negedge clock);
         n = n + 1;
      end
      if (n >= 400)
         fail_count = fail_count + 1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_memory_model.rom[12'h040] = 8'h40;
      i_memory_model.rom[12'h041] = 8'h40;
      @(negedge clock);
      for (k = 0; k < 30; k = k + 1)
      begin
         a = $random(seed);
         c = $random(seed);
         m = (k < 16) ? k[3:0] : 4'($random(seed));
         start;
         emit({4'hd, a, c ? 8'hfa : 8'hf1});
         emit({4'hf, m, 8'h00});
         emit(16'h4040);
         run;
         e = acc_op(m, a, c);
         check("acc", accumulator, e[3:0]);
         check("carry", carry, e[4]);
         if (m == 4'hd)
            check("command_line", command_line, a[2:0]);
      end
      for (k = 0; k < 24; k = k + 1)
      begin
         a = $random(seed);
         v = $random(seed);
         r = $random(seed);
         c = $random(seed);
         op = 4'(8 + k % 3);
         start;
         emit({4'hd, a, 4'hb, r});
         emit({4'h6, r, 4'hd, v});
         emit({c ? 8'hfa : 8'hf1, op, r});
         emit(16'h4040);
         run;
         e = add_sub(op, v, a + 4'h1, c);
         check("acc", accumulator, e[3:0]);
         check("carry", carry, e[4]);
      end
      for (k = 0; k < 30; k = k + 1)
      begin
         w = $random(seed);
         r = $random(seed);
         m = $random(seed);
         a = k[0] ? 4'h0 : 4'($random(seed));
         c = $random(seed);
         start;
         emit({4'hd, w, 4'hb, r});
         emit({4'hd, a, c ? 8'hfa : 8'hf1});
         emit({k % 3 == 0 ? {4'h7, r} : {4'h1, m}, 8'h0a});
         emit(16'hd140);
         emit(16'h4000);
         emit(16'hd240);
         emit(16'h4000);
         run;
         j = (k % 3 == 0) ? (w + 4'h1 != 4'h0) : jump_taken(m, a, c, test_input);
         check("acc", accumulator, j ? 4'h2 : 4'h1);
      end
      for (k = 0; k < 24; k = k + 1)
      begin
         b = $random(seed);
         r = $random(seed);
         v = $random(seed);
         w = $random(seed);
         start;
         i_memory_model.rom[12'h030] = b;
         if (k < 12)
         begin
            emit(16'h2030);
            emit({4'h3, r[2:0], 1'b0, 8'h50});
            emit({8'h10, 4'h8, r[2:0], 1'b1});
            emit(16'h4040);
            pc = 12'h010;
            emit({4'hc, v, 8'h00});
            run;
            e = add_sub(4'h8, v, b[3:0], 1'b0);
            check("acc", accumulator, e[3:0]);
            check("carry", carry, e[4]);
         end
         else
         begin
            emit({4'h2, r[2:0], 1'b0, b});
            emit({4'h2, r[2:0], 1'b1, 4'hd, v});
            emit({6'b111001, r[3:2], 6'b111000, 2'(k % 3 + 1)});
            emit({4'hd, w, 8'he0});
            emit({8'hd0, 6'b111011, r[3:2]});
            emit(16'hf1eb);
            emit(16'h4040);
            run;
            e = add_sub(4'h8, v, w, 1'b0);
            check("acc", accumulator, e[3:0]);
            check("carry", carry, e[4]);
            check("chip_select_address", chip_select_address, b);
            check("ram_main", i_memory_model.ram_main[b], w);
         end
      end
      tally_and_finish;
   end
endmodule
